// >>> slwsc_pkg.sv
// constants and state layout of the late-write synchronous sram core
// assumes one clock, synchronous active-high reset, static mode straps
package slwsc_pkg;

    // array geometry: four nine-bit byte lanes per word
    localparam int ADDR_W  = 18;
    localparam int DEPTH   = 262144;
    localparam int LANES   = 4;
    localparam int LANE_W  = 9;
    localparam int DATA_W  = 36;
    localparam int BURST_W = 2;

    // burst counter values
    localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
    localparam logic [BURST_W-1:0] BURST_ONE  = 2'h1;

    // reset values
    localparam logic [ADDR_W-1:0] ADDR_RST  = 18'h00000;
    localparam logic [LANES-1:0]  BE_NONE   = 4'h0;
    localparam logic [DATA_W-1:0] DATA_RST  = 36'h000000000;

    // command held for burst continuation
    typedef enum logic [1:0] {
        OP_IDLE  = 2'b00,
        OP_READ  = 2'b01,
        OP_WRITE = 2'b10
    } slwsc_op_t;

    // all register state of the core apart from the lane arrays
    typedef struct packed {
        slwsc_op_t          last_op;
        logic [ADDR_W-1:0]  base_addr;
        logic [BURST_W-1:0] burst_cnt;
        logic               p1_rd;
        logic               p1_wr;
        logic [LANES-1:0]   p1_be;
        logic [ADDR_W-1:0]  p1_addr;
        logic               p2_wr;
        logic [LANES-1:0]   p2_be;
        logic [ADDR_W-1:0]  p2_addr;
        logic               out_valid;
        logic [DATA_W-1:0]  out_data;
    } slwsc_state_t;

    localparam slwsc_state_t STATE_RST = '{
        last_op:   OP_IDLE,
        base_addr: ADDR_RST,
        burst_cnt: BURST_ZERO,
        p1_rd:     1'b0,
        p1_wr:     1'b0,
        p1_be:     BE_NONE,
        p1_addr:   ADDR_RST,
        p2_wr:     1'b0,
        p2_be:     BE_NONE,
        p2_addr:   ADDR_RST,
        out_valid: 1'b0,
        out_data:  DATA_RST
    };

endpackage : slwsc_pkg

// >>> slwsc_core.sv
// synchronous sram core with late write and no bus turnaround
// assumes the controller presents write data at the matching late edge
// and holds the burst-order and mode straps static

// Behaviour
// - only control, address, data sampled on edges
// - clock gate high suspends all operation
// - advance_load low loads a fresh address
// - selected only with all three selects active
// - read starts on selected load with write high
// - pipelined read data appears one edge later
// - write starts on selected load with write low
// - byte selects pick lanes, ignored on reads
// - write with no byte selects changes nothing
// - flow-through read data follows the command edge
// - read may be followed directly by write
// - writes timed internally from the clock edge
// - output enable high forces drivers off
// - sleep input forces power-down
// - mode strap low flow-through, high pipelined
// - low address bits preload the burst counter
// - each lane is nine bits wide
// - advance high steps counter and uses it
// - counter wraps after four, linear or interleaved
// - drivers off during write data cycles
// - gated clock keeps bus driven or released
module slwsc_core (
    input  wire logic                         I_MCLK,
    input  wire logic                         I_RESET,
    input  wire logic                         I_CLK_GATE_N,
    input  wire logic                         I_ADVANCE_LOAD,
    input  wire logic                         I_WRITE_N,
    input  wire logic [slwsc_pkg::LANES-1:0]  I_BYTE_SEL_N,
    input  wire logic                         I_CHIP_SEL1_N,
    input  wire logic                         I_CHIP_SEL2,
    input  wire logic                         I_CHIP_SEL3_N,
    input  wire logic [slwsc_pkg::ADDR_W-1:0] I_ADDR,
    input  wire logic                         I_OUT_EN_N,
    input  wire logic                         I_SLEEP_REQ,
    input  wire logic                         I_FLOW_MODE_N,
    input  wire logic                         I_LINEAR_ORDER_N,
    input  wire logic [slwsc_pkg::DATA_W-1:0] I_DATA,
    output logic      [slwsc_pkg::DATA_W-1:0] O_DATA,
    output logic                              O_DATA_OE_N,
    output logic                              O_POWER_DOWN
);

    slwsc_pkg::slwsc_state_t        st;
    slwsc_pkg::slwsc_state_t        next_st;
    slwsc_pkg::slwsc_op_t           cmd_op;
    logic [slwsc_pkg::ADDR_W-1:0]   cmd_addr;
    logic [slwsc_pkg::BURST_W-1:0]  step_cnt;
    logic [slwsc_pkg::BURST_W-1:0]  burst_low;
    logic [slwsc_pkg::ADDR_W-1:0]   rd_addr;
    logic [slwsc_pkg::DATA_W-1:0]   rd_word;
    logic [slwsc_pkg::ADDR_W-1:0]   wr_addr;
    logic [slwsc_pkg::LANES-1:0]    wr_be;
    logic                           wr_go;
    logic                           selected;
    logic                           run;
    logic                           pipe;

    // edges count only with the gate low and out of sleep
    assign run      = ~I_CLK_GATE_N & ~I_SLEEP_REQ;
    assign selected = ~I_CHIP_SEL1_N & I_CHIP_SEL2 & ~I_CHIP_SEL3_N;
    assign pipe     = I_FLOW_MODE_N;

    always_comb begin
        next_st  = st;
        step_cnt = st.burst_cnt + slwsc_pkg::BURST_ONE;
        // interleaved order xors the step into the start bits
        if (I_LINEAR_ORDER_N) begin
            burst_low = st.base_addr[1:0] ^ step_cnt;
        end else begin
            burst_low = st.base_addr[1:0] + step_cnt;
        end
        if (!I_ADVANCE_LOAD) begin
            cmd_addr = I_ADDR;
            if (!selected) begin
                cmd_op = slwsc_pkg::OP_IDLE;
            end else if (I_WRITE_N) begin
                cmd_op = slwsc_pkg::OP_READ;
            end else begin
                cmd_op = slwsc_pkg::OP_WRITE;
            end
        end else begin
            // continuation keeps the operation of the burst
            cmd_addr = {st.base_addr[slwsc_pkg::ADDR_W-1:2], burst_low};
            cmd_op   = st.last_op;
        end
        // late write stage: two edges pipelined, one edge flow-through
        if (pipe) begin
            wr_go   = run & st.p2_wr & ~I_RESET;
            wr_addr = st.p2_addr;
            wr_be   = st.p2_be;
            rd_addr = st.p1_addr;
        end else begin
            wr_go   = run & st.p1_wr & ~I_RESET;
            wr_addr = st.p1_addr;
            wr_be   = st.p1_be;
            rd_addr = cmd_addr;
        end
        if (run) begin
            next_st.last_op = cmd_op;
            if (!I_ADVANCE_LOAD) begin
                next_st.base_addr = I_ADDR;
                next_st.burst_cnt = slwsc_pkg::BURST_ZERO;
            end else begin
                next_st.burst_cnt = step_cnt;
            end
            next_st.p1_rd   = (cmd_op == slwsc_pkg::OP_READ);
            next_st.p1_wr   = (cmd_op == slwsc_pkg::OP_WRITE);
            next_st.p1_addr = cmd_addr;
            // byte selects count only with a write command
            if (cmd_op == slwsc_pkg::OP_WRITE) begin
                next_st.p1_be = ~I_BYTE_SEL_N;
            end else begin
                next_st.p1_be = slwsc_pkg::BE_NONE;
            end
            next_st.p2_wr   = st.p1_wr;
            next_st.p2_be   = st.p1_be;
            next_st.p2_addr = st.p1_addr;
            if (pipe) begin
                next_st.out_valid = st.p1_rd;
                if (st.p1_rd) begin
                    next_st.out_data = rd_word;
                end
            end else begin
                next_st.out_valid = (cmd_op == slwsc_pkg::OP_READ);
                if (cmd_op == slwsc_pkg::OP_READ) begin
                    next_st.out_data = rd_word;
                end
            end
        end
    end

    // state advances only on run edges, otherwise it holds
    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            st <= slwsc_pkg::STATE_RST;
        end else begin
            st <= next_st;
        end
    end

    // one nine-bit array per byte lane
    for (genvar g = 0; g < slwsc_pkg::LANES; g++) begin : g_lane
        logic [slwsc_pkg::LANE_W-1:0] lane_mem [slwsc_pkg::DEPTH];

        always_ff @(posedge I_MCLK) begin
            if (wr_go && wr_be[g]) begin
                lane_mem[wr_addr] <=
                    I_DATA[g*slwsc_pkg::LANE_W +: slwsc_pkg::LANE_W];
            end
        end

        assign rd_word[g*slwsc_pkg::LANE_W +: slwsc_pkg::LANE_W] =
            lane_mem[rd_addr];
    end

    // out_valid is never set for a write slot, so writes release the bus
    assign O_DATA       = st.out_data;
    assign O_DATA_OE_N  = ~(st.out_valid & ~I_OUT_EN_N & ~I_SLEEP_REQ);
    assign O_POWER_DOWN = I_SLEEP_REQ;

    // checks

    hold_gate_a: assert property (
        @(posedge I_MCLK) disable iff (I_RESET)
        !run |=> $stable(st))
        else $error("state moved on a blocked edge");

    desel_load_a: assert property (
        @(posedge I_MCLK) disable iff (I_RESET)
        run && !I_ADVANCE_LOAD && !selected
        |=> st.last_op == slwsc_pkg::OP_IDLE && !st.p1_rd && !st.p1_wr)
        else $error("deselect load started an access");

    read_start_a: assert property (
        @(posedge I_MCLK) disable iff (I_RESET)
        run && !I_ADVANCE_LOAD && selected && I_WRITE_N
        |=> st.p1_rd && st.p1_addr == $past(I_ADDR))
        else $error("read not latched with its address");

    write_start_a: assert property (
        @(posedge I_MCLK) disable iff (I_RESET)
        run && !I_ADVANCE_LOAD && selected && !I_WRITE_N
        |=> st.p1_wr && st.p1_be == ~$past(I_BYTE_SEL_N))
        else $error("write not latched with its byte selects");

    read_no_be_a: assert property (
        @(posedge I_MCLK) disable iff (I_RESET)
        run && !I_ADVANCE_LOAD && selected && I_WRITE_N
        |=> st.p1_be == slwsc_pkg::BE_NONE)
        else $error("byte selects kept on a read");

    pipe_latency_a: assert property (
        @(posedge I_MCLK) disable iff (I_RESET)
        run && pipe && cmd_op == slwsc_pkg::OP_READ ##1 (run && pipe)
        |=> st.out_valid && st.out_data == $past(rd_word))
        else $error("pipelined read data not out one edge later");

    flow_latency_a: assert property (
        @(posedge I_MCLK) disable iff (I_RESET)
        run && !pipe && cmd_op == slwsc_pkg::OP_READ
        |=> st.out_valid && st.out_data == $past(rd_word))
        else $error("flow-through read data not out after the edge");

    pipe_write_a: assert property (
        @(posedge I_MCLK) disable iff (I_RESET)
        run && pipe && cmd_op == slwsc_pkg::OP_WRITE && I_ADVANCE_LOAD == 1'b0
        ##1 (run && pipe) ##1 (run && pipe)
        |-> wr_go && wr_addr == $past(I_ADDR, 2))
        else $error("pipelined write not two edges after command");

    flow_write_a: assert property (
        @(posedge I_MCLK) disable iff (I_RESET)
        run && !pipe && cmd_op == slwsc_pkg::OP_WRITE
        ##1 (run && !pipe)
        |-> wr_go && wr_be == ~$past(I_BYTE_SEL_N))
        else $error("flow-through write not one edge after command");

    write_off_a: assert property (
        @(posedge I_MCLK) disable iff (I_RESET)
        wr_go |-> O_DATA_OE_N)
        else $error("drivers on during a write data cycle");

    oe_force_a: assert property (
        @(posedge I_MCLK) disable iff (I_RESET)
        I_OUT_EN_N || I_SLEEP_REQ |-> O_DATA_OE_N)
        else $error("drivers on with output enable or sleep");

    gate_bus_a: assert property (
        @(posedge I_MCLK) disable iff (I_RESET)
        !run ##1 (!I_OUT_EN_N && !I_SLEEP_REQ)
        |-> O_DATA_OE_N == !$past(st.out_valid))
        else $error("bus state changed while the gate was high");

    burst_step_a: assert property (
        @(posedge I_MCLK) disable iff (I_RESET)
        run && I_ADVANCE_LOAD
        |=> st.burst_cnt == $past(step_cnt)
            && st.p1_addr[1:0] == $past(burst_low)
            && st.p1_addr[slwsc_pkg::ADDR_W-1:2]
               == $past(st.base_addr[slwsc_pkg::ADDR_W-1:2]))
        else $error("continuation did not use the counter address");

    burst_wrap_a: assert property (
        @(posedge I_MCLK) disable iff (I_RESET)
        (run && !I_ADVANCE_LOAD) ##1 (run && I_ADVANCE_LOAD)[*4]
        |=> st.p1_addr[1:0] == st.base_addr[1:0])
        else $error("burst did not wrap after four accesses");

    preload_a: assert property (
        @(posedge I_MCLK) disable iff (I_RESET)
        run && !I_ADVANCE_LOAD
        |=> st.burst_cnt == slwsc_pkg::BURST_ZERO
            && st.base_addr[1:0] == $past(I_ADDR[1:0]))
        else $error("load did not preload the burst counter");

    noop_write_a: assert property (
        @(posedge I_MCLK) disable iff (I_RESET)
        run && cmd_op == slwsc_pkg::OP_WRITE && I_BYTE_SEL_N == 4'hF
        |=> st.p1_wr && st.p1_be == slwsc_pkg::BE_NONE)
        else $error("no-op write carried byte selects");

    power_pass_a: assert property (
        @(posedge I_MCLK) disable iff (I_RESET)
        O_POWER_DOWN == I_SLEEP_REQ)
        else $error("power-down does not follow sleep");

    sleep_hold_a: assert property (
        @(posedge I_MCLK) disable iff (I_RESET)
        I_SLEEP_REQ |=> $stable(st))
        else $error("state moved during sleep");

    pipe_wr_off_a: assert property (
        @(posedge I_MCLK) disable iff (I_RESET)
        run && pipe && st.p1_wr |=> !st.out_valid)
        else $error("pipelined write slot kept drivers on");

    flow_wr_off_a: assert property (
        @(posedge I_MCLK) disable iff (I_RESET)
        run && !pipe && cmd_op == slwsc_pkg::OP_WRITE |=> !st.out_valid)
        else $error("flow-through write slot kept drivers on");

    read_write_a: assert property (
        @(posedge I_MCLK) disable iff (I_RESET)
        run && cmd_op == slwsc_pkg::OP_READ
        ##1 (run && cmd_op == slwsc_pkg::OP_WRITE)
        |=> st.p1_wr)
        else $error("write right after read was not taken");

    pipe_rd_data_a: assert property (
        @(posedge I_MCLK) disable iff (I_RESET)
        run && pipe && st.p1_rd
        |=> st.out_valid && st.out_data == $past(rd_word))
        else $error("pipelined read data not registered");

    select_cmd_a: assert property (
        @(posedge I_MCLK) disable iff (I_RESET)
        !selected && !I_ADVANCE_LOAD |-> cmd_op == slwsc_pkg::OP_IDLE)
        else $error("deselected load decoded as an access");

    late_stage_a: assert property (
        @(posedge I_MCLK) disable iff (I_RESET)
        run && pipe && st.p2_wr |-> wr_go && wr_addr == st.p2_addr)
        else $error("pipelined late write not issued on the edge");

    gate_drive_a: assert property (
        @(posedge I_MCLK) disable iff (I_RESET)
        !run && st.out_valid && !I_OUT_EN_N && !I_SLEEP_REQ
        |-> !O_DATA_OE_N)
        else $error("bus released while a read was held");

    cont_be_a: assert property (
        @(posedge I_MCLK) disable iff (I_RESET)
        run && I_ADVANCE_LOAD && st.last_op == slwsc_pkg::OP_WRITE
        |=> st.p1_be == ~$past(I_BYTE_SEL_N))
        else $error("burst write ignored its byte selects");

    cont_op_a: assert property (
        @(posedge I_MCLK) disable iff (I_RESET)
        run && I_ADVANCE_LOAD |=> st.last_op == $past(st.last_op))
        else $error("continuation changed the burst operation");

endmodule : slwsc_core

// >>> slwsc_ctrl_model.sv
// controller-side model: presents late write data on the data inputs
// assumes the bench drives the command pins and flags each write on i_wr
module slwsc_ctrl_model (
    input  wire logic                         i_mclk,
    input  wire logic                         i_reset,
    input  wire logic                         i_clk_gate_n,
    input  wire logic                         i_sleep_req,
    input  wire logic                         i_flow_mode_n,
    input  wire logic                         i_wr,
    input  wire logic [slwsc_pkg::DATA_W-1:0] i_wdata,
    output logic      [slwsc_pkg::DATA_W-1:0] o_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic                         held_wr;
    logic [slwsc_pkg::DATA_W-1:0] held_data;
    initial o_data = '0;
    always @(posedge i_mclk) begin
        if (i_reset) begin
            held_wr <= 1'b0;
        end else if (!i_clk_gate_n && !i_sleep_req) begin
            held_wr   <= i_wr;
            held_data <= i_wdata;
            // bus released: inverse of last value, never stale data
            if (!i_flow_mode_n) begin
                o_data <= i_wr ? i_wdata : ~o_data;
            end else begin
                o_data <= held_wr ? held_data : ~o_data;
            end
        end
    end
endmodule : slwsc_ctrl_model

// >>> sync_late_write_sram_core_tb.sv
// self-checking bench for the late-write sram core
// assumes slwsc_pkg, slwsc_core and slwsc_ctrl_model are compiled first
module sync_late_write_sram_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk, rst, gate_n, advance_load, wr_n, cs1_n, cs2, cs3_n;
    logic        oe_n, sleep, flow_n, lin_n, wr, doe_n, pd;
    logic [3:0]  bsel_n;
    logic [17:0] addr;
    logic [35:0] wdata, din, dout;
    int          checks = 0;
    int          fail_count = 0;
    slwsc_core uut (
        .I_MCLK(mclk), .I_RESET(rst), .I_CLK_GATE_N(gate_n),
        .I_ADVANCE_LOAD(advance_load), .I_WRITE_N(wr_n), .I_BYTE_SEL_N(bsel_n),
        .I_CHIP_SEL1_N(cs1_n), .I_CHIP_SEL2(cs2), .I_CHIP_SEL3_N(cs3_n),
        .I_ADDR(addr), .I_OUT_EN_N(oe_n), .I_SLEEP_REQ(sleep),
        .I_FLOW_MODE_N(flow_n), .I_LINEAR_ORDER_N(lin_n), .I_DATA(din),
        .O_DATA(dout), .O_DATA_OE_N(doe_n), .O_POWER_DOWN(pd));
    slwsc_ctrl_model ctrl (
        .i_mclk(mclk), .i_reset(rst), .i_clk_gate_n(gate_n),
        .i_sleep_req(sleep), .i_flow_mode_n(flow_n), .i_wr(wr),
        .i_wdata(wdata), .o_data(din));
    always #10 mclk = ~mclk;
    task automatic chk(input string n, input logic [35:0] e,
                       input logic [35:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic cmd(input logic w, input logic a, input logic [3:0] b,
                       input logic [17:0] ad, input logic [35:0] d);
        @(posedge mclk);
        advance_load    <= a;
        wr_n   <= !w;
        wr     <= w;
        bsel_n <= b;
        addr   <= ad;
        wdata  <= d;
        cs1_n  <= 1'b0;
        cs2    <= 1'b1;
        cs3_n  <= 1'b0;
    endtask : cmd
    task automatic desel();
        @(posedge mclk);
        advance_load   <= 1'b0;
        wr    <= 1'b0;
        cs1_n <= 1'b1;
    endtask : desel
    task automatic t_pipe();
        cmd(1, 0, 4'h0, 18'h00010, 36'h123456789);
        cmd(1, 0, 4'h0, 18'h00011, 36'h000000000);
        cmd(1, 0, 4'hA, 18'h00011, 36'hFFFFFFFFF);
        cmd(1, 0, 4'hF, 18'h00010, 36'hFFFFFFFFF);
        desel();
        desel();
        cmd(0, 0, 4'h0, 18'h00010, '0);
        cmd(0, 0, 4'h0, 18'h00011, '0);
        cmd(1, 0, 4'h0, 18'h00012, 36'h0F0F0F0F0);
        #1 chk("pipe rd a", 36'h123456789, dout);
        desel();
        #1 chk("pipe rd b", 36'h007FC01FF, dout);
        desel();
        #1 chk("wr oe", 36'h1, 36'(doe_n));
        cmd(0, 0, 4'h0, 18'h00012, '0);
        cmd(0, 0, 4'h0, 18'h00010, '0);
        desel();
        oe_n <= 1'b1;
        #1 chk("pipe rd c", 36'h0F0F0F0F0, dout);
        chk("oe off", 36'h1, 36'(doe_n));
        desel();
        oe_n <= 1'b0;
        #1 chk("nop kept", 36'h123456789, dout);
        chk("oe on", 36'h0, 36'(doe_n));
        $display("t_pipe done");
    endtask : t_pipe
    task automatic t_flow();
        desel();
        flow_n <= 1'b0;
        cmd(1, 0, 4'h0, 18'h00020, 36'h5A5A5A5A5);
        desel();
        cmd(0, 0, 4'h0, 18'h00020, '0);
        cmd(1, 0, 4'h0, 18'h00021, 36'h2468ACE13);
        #1 chk("flow rd", 36'h5A5A5A5A5, dout);
        desel();
        #1 chk("flow wr oe", 36'h1, 36'(doe_n));
        cmd(0, 0, 4'h0, 18'h00021, '0);
        desel();
        #1 chk("flow late wr", 36'h2468ACE13, dout);
        flow_n <= 1'b1;
        $display("t_flow done");
    endtask : t_flow
    task automatic t_burst(input logic lin);
        logic [1:0] lo;
        desel();
        lin_n <= lin;
        for (int k = 0; k < 4; k++) cmd(1, 0, 4'h0, 18'(48 + k), 36'(256 + k));
        desel();
        desel();
        for (int i = 0; i < 7; i++) begin
            if (i < 5) cmd(0, i != 0, 4'h0, i ? 18'h3FFFF : 18'h00031, '0);
            else desel();
            lo = lin ? 2'(1 ^ (i - 2)) : 2'(1 + i - 2);
            if (i > 1) #1 chk("burst rd", 36'(256 + lo), dout);
        end
        $display("t_burst done");
    endtask : t_burst
    task automatic t_gate();
        cmd(0, 0, 4'h0, 18'h00030, '0);
        desel();
        cmd(0, 0, 4'h0, 18'h00031, '0);
        gate_n <= 1'b1;
        #1 chk("gate rd", 36'h100, dout);
        repeat (2) begin
            @(posedge mclk);
            #1 chk("gate hold", 36'h100, dout);
            chk("gate drive", 36'h0, 36'(doe_n));
        end
        @(posedge mclk);
        gate_n <= 1'b0;
        desel();
        desel();
        sleep <= 1'b1;
        #1 chk("gate resume", 36'h101, dout);
        chk("sleep pd", 36'h1, 36'(pd));
        chk("sleep oe", 36'h1, 36'(doe_n));
        desel();
        sleep <= 1'b0;
        for (int s = 0; s < 3; s++) begin
            @(posedge mclk);
            advance_load   <= 1'b0;
            wr_n  <= 1'b1;
            wr    <= 1'b0;
            addr  <= 18'h00030;
            cs1_n <= (s == 0);
            cs2   <= (s != 1);
            cs3_n <= (s == 2);
            desel();
            desel();
            #1 chk("desel oe", 36'h1, 36'(doe_n));
        end
        $display("t_gate done");
    endtask : t_gate
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict
    initial begin
        {mclk, advance_load, wr_n, cs2, cs3_n, oe_n, sleep, wr, gate_n} = '0;
        {rst, cs1_n, flow_n, lin_n} = 4'hF;
        bsel_n = 4'hF;
        addr   = '0;
        wdata  = '0;
        repeat (20) @(posedge mclk);
        #1 chk("rst oe", 36'h1, 36'(doe_n));
        chk("rst data", 36'h0, dout);
        @(posedge mclk);
        rst <= 1'b0;
        t_pipe();
        t_flow();
        t_burst(1'b0);
        t_burst(1'b1);
        t_gate();
        give_verdict();
    end
endmodule : sync_late_write_sram_core_tb
